// ---- pkg/trace_pkg.sv ----
package trace_pkg;

  // Sizes of the stores
  localparam int CODE_AW = 13;
  localparam int DM_AW = 11;
  localparam int TRACE_IW = 13;
  localparam int TRACE_DEPTH = 8192;
  localparam int TRACE_W = 64;
  localparam int COV_BITS = 8192;

  // Highest covered code address per chip mode
  localparam logic [12:0] CODE_LIMIT_SMALL = 13'h07df;
  localparam logic [12:0] CODE_LIMIT_MID = 13'h0fdf;
  localparam logic [12:0] CODE_LIMIT_LARGE = 13'h1fdf;

  // Data memory window per chip mode
  localparam logic [10:0] DM_BASE_SMALL = 11'h780;
  localparam logic [10:0] DM_BASE_MID = 11'h700;
  localparam logic [10:0] DM_BASE_LARGE = 11'h600;
  localparam logic [10:0] DM_TOP = 11'h7ff;

  // Trace field fill and reset values
  localparam logic [3:0] DM_PAD_NIBBLE = 4'hf;
  localparam logic [7:0] DM_FIELD_RST = 8'hff;
  localparam logic [10:0] DM_ADDR_RST = 11'h700;
  localparam logic [12:0] TRACE_LAST_IDX = 13'h1fff;
  localparam logic [12:0] TRACE_PTR_RST = 13'h0000;

  typedef enum logic [1:0] {
    MODE_SMALL = 2'b00,
    MODE_MID = 2'b01,
    MODE_LARGE = 2'b10
  } chip_mode_t;

  typedef enum logic [1:0] {
    GRP_FLAGS = 2'b01,
    GRP_P4_P0 = 2'b10,
    GRP_P4_P1 = 2'b11
  } trace_group_t;

  typedef struct packed {
    logic [3:0] b;
    logic [3:0] a;
    logic [3:0] h;
    logic [3:0] l;
    logic carry;
    logic [7:0] sp;
    logic [3:0] port_zero;
    logic [3:0] port_one;
    logic [3:0] port_two;
    logic [3:0] port_three;
    logic [3:0] port_four;
    logic condition_flag_one;
    logic condition_flag_two;
    logic [3:0] status_reg_low;
    logic [3:0] status_reg_high;
  } core_state_t;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
    logic wide;
  } dm_write_t;

  typedef struct packed {
    logic [6:0] pad;
    logic [3:0] b;
    logic [3:0] a;
    logic [3:0] h;
    logic [3:0] l;
    logic carry;
    logic [7:0] sp;
    logic [7:0] dm;
    logic [3:0] port_two;
    logic [3:0] port_three;
    logic [15:0] extra;
  } trace_entry_t;

endpackage : trace_pkg

// ---- design/coverage_bits.sv ----
`timescale 1ns/1ps
module coverage_bits
  import trace_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire chip_mode_t mode_i,
  input wire logic clear_i,
  input wire logic set_i,
  input wire logic [12:0] set_addr_i,
  input wire logic [12:0] rd_addr_i,
  output logic rd_data_o
);

  logic [COV_BITS-1:0] cov_q;
  logic [12:0] limit;
  logic in_span;

  // Span of the bit store for the chip mode
  always_comb begin
    case (mode_i)
      MODE_SMALL: limit = CODE_LIMIT_SMALL;
      MODE_MID: limit = CODE_LIMIT_MID;
      default: limit = CODE_LIMIT_LARGE;
    endcase
  end
  assign in_span = set_addr_i <= limit;

  // Clear on start wins, then executed addresses set their bit
  always_ff @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      cov_q <= '0;
    end else if (set_i && in_span) begin
      cov_q[set_addr_i] <= 1'b1;
    end
  end

  // Registered read for the debugger
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= 1'b0;
    end else begin
      rd_data_o <= cov_q[rd_addr_i];
    end
  end

  property p_cov_set;
    @(posedge clk_i) disable iff (srst_i)
    set_i && in_span && !clear_i |=> cov_q[$past(set_addr_i)];
  endproperty
  a_cov_set: assert property (p_cov_set)
    else $error("coverage bit not set");

  property p_cov_clear;
    @(posedge clk_i) disable iff (srst_i)
    clear_i |=> cov_q == '0;
  endproperty
  a_cov_clear: assert property (p_cov_clear)
    else $error("coverage not cleared on start");

endmodule : coverage_bits

// ---- design/trace_ring.sv ----
`timescale 1ns/1ps
module trace_ring
  import trace_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic [12:0] wr_idx_i,
  input wire trace_entry_t wr_data_i,
  input wire logic [12:0] rd_idx_i,
  output trace_entry_t rd_data_o
);

  // 8192 x 64 snapshot store
  logic [TRACE_W-1:0] mem [TRACE_DEPTH];

  // Write port at the write pointer
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule : trace_ring

// ---- design/trace_capture.sv ----
// Behaviour
// - Each executed instruction address sets its coverage bit to one.
// - Starting emulation at an explicit address clears all coverage bits.
// - Coverage spans 0 to 7DF, FDF or 1FDF by chip mode.
// - Data memory window ends 7FF, begins 780, 700 or 600 by mode.
// - Trace store holds 8192 entries of 64 bits, one per step.
// - Trace store is a ring; new entries overwrite the oldest.
// - Before wrap, only entries 0 up to the pointer are valid.
// - After wrap all entries valid; reading back past 0 wraps to 8191.
// - Entry holds B, A, H, L, carry, SP, traced data, ports 2, 3, extra.
// - Extra group: flags and status, port four/zero, or port four/one.
// - Writes matching an in-window trace address load the data field.
// - Narrow writes pad upper nibble with F; wide writes keep 8 bits.
// - Writes to other addresses leave the data field unchanged.
// - In the smallest chip mode the port four field is absent.
// - State changes show in the entry one instruction later.
// - Changing the group zeroes the pointer; reset selects flags group.
// - In address tracing, only steps with trace-enable bit set record.
`timescale 1ns/1ps
module trace_capture
  import trace_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire chip_mode_t chip_mode_i,
  input wire logic run_i,
  input wire logic start_i,
  input wire logic step_valid_i,
  input wire logic [12:0] step_pc_i,
  input wire logic step_trace_en_i,
  input wire core_state_t core_state_i,
  input wire logic dm_wr_valid_i,
  input wire dm_write_t dm_wr_i,
  input wire logic addr_trace_mode_i,
  input wire logic set_trace_data_address_cmd_i,
  input wire logic [10:0] trace_data_addr_i,
  input wire logic select_trace_group_cmd_i,
  input wire trace_group_t trace_group_i,
  input wire logic [12:0] cov_rd_addr_i,
  output logic cov_rd_data_o,
  input wire logic rd_req_i,
  input wire logic rd_back_i,
  input wire logic [12:0] rd_num_i,
  output logic rd_valid_o,
  output logic rd_ok_o,
  output trace_entry_t rd_data_o,
  output logic [12:0] trace_write_pointer_o,
  output logic wrapped_o,
  output trace_group_t trace_group_o,
  output logic [10:0] trace_data_addr_o,
  output logic dm_addr_ok_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [12:0] wp_q;
  logic wrapped_q;
  trace_group_t group_q;
  logic [10:0] tda_q;
  logic [7:0] dm_q;
  core_state_t snap_q;
  logic rd_valid_q;
  logic rd_ok_q;
  logic [10:0] dm_base;
  logic tda_in_win;
  logic dm_hit;
  logic group_change;
  logic rec;
  logic [3:0] p4_eff;
  logic [15:0] extra;
  trace_entry_t entry;
  logic [12:0] rd_idx;
  logic rd_ok_d;

  ////////////////////////////////////////////////////////////////////////////
  // Data memory window and trace address

  // Base of the data window for the chip mode
  always_comb begin
    case (chip_mode_i)
      MODE_SMALL: dm_base = DM_BASE_SMALL;
      MODE_MID: dm_base = DM_BASE_MID;
      default: dm_base = DM_BASE_LARGE;
    endcase
  end

  // Traced address must lie in the window
  assign tda_in_win = (tda_q >= dm_base) && (tda_q <= DM_TOP);

  // Traced address, loaded by the debugger
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tda_q <= DM_ADDR_RST;
    end else if (set_trace_data_address_cmd_i) begin
      tda_q <= trace_data_addr_i;
    end
  end

  // Write address compare against the traced address
  assign dm_hit = dm_wr_valid_i && run_i && tda_in_win
    && (dm_wr_i.addr == tda_q);

  // Captured data value; non-matching writes leave it alone
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dm_q <= DM_FIELD_RST;
    end else if (dm_hit) begin
      if (dm_wr_i.wide) begin
        dm_q <= dm_wr_i.data;
      end else begin
        dm_q <= {DM_PAD_NIBBLE, dm_wr_i.data[3:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Group selection and pointer

  // Group register, flags group after reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      group_q <= GRP_FLAGS;
    end else if (select_trace_group_cmd_i) begin
      group_q <= trace_group_i;
    end
  end

  assign group_change = select_trace_group_cmd_i
    && (trace_group_i != group_q);

  // Record a step, gated by the enable bit in address tracing
  assign rec = step_valid_i && run_i
    && (!addr_trace_mode_i || step_trace_en_i);

  // Ring pointer; clearing events win over a step
  always_ff @(posedge clk_i) begin
    if (srst_i || group_change || start_i) begin
      wp_q <= TRACE_PTR_RST;
    end else if (rec) begin
      wp_q <= wp_q + 13'd1;
    end
  end

  // Sticky wrap flag, set on first pass over the last entry
  always_ff @(posedge clk_i) begin
    if (srst_i || group_change || start_i) begin
      wrapped_q <= 1'b0;
    end else if (rec && (wp_q == TRACE_LAST_IDX)) begin
      wrapped_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry assembly

  // Snapshot taken at each step, written with the next step
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      snap_q <= '0;
    end else if (step_valid_i && run_i) begin
      snap_q <= core_state_i;
    end
  end

  // Port four absent in smallest mode
  assign p4_eff = (chip_mode_i == MODE_SMALL) ? 4'h0
    : snap_q.port_four;

  // Extra group selection
  always_comb begin
    case (group_q)
      GRP_P4_P0: extra = {8'h00, p4_eff, snap_q.port_zero};
      GRP_P4_P1: extra = {8'h00, p4_eff, snap_q.port_one};
      default: extra = {6'h00, snap_q.condition_flag_one,
        snap_q.condition_flag_two, snap_q.status_reg_low,
        snap_q.status_reg_high};
    endcase
  end

  // Full entry
  always_comb begin
    entry = '0;
    entry.b = snap_q.b;
    entry.a = snap_q.a;
    entry.h = snap_q.h;
    entry.l = snap_q.l;
    entry.carry = snap_q.carry;
    entry.sp = snap_q.sp;
    entry.dm = dm_q;
    entry.port_two = snap_q.port_two;
    entry.port_three = snap_q.port_three;
    entry.extra = extra;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stores

  coverage_bits u_cov (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .mode_i(chip_mode_i),
    .clear_i(start_i),
    .set_i(step_valid_i && run_i),
    .set_addr_i(step_pc_i),
    .rd_addr_i(cov_rd_addr_i),
    .rd_data_o(cov_rd_data_o)
  );

  trace_ring u_ring (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_en_i(rec && !group_change && !start_i),
    .wr_idx_i(wp_q),
    .wr_data_i(entry),
    .rd_idx_i(rd_idx),
    .rd_data_o(rd_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  // Index from start or from steps back; 13-bit math wraps past 0
  assign rd_idx = rd_back_i ? (wp_q - rd_num_i) : rd_num_i;

  // Entry holds data if wrapped or below the pointer
  assign rd_ok_d = wrapped_q || (rd_idx < wp_q);

  // Answer strobe and validity one cycle after the request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_valid_q <= 1'b0;
      rd_ok_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_req_i;
      rd_ok_q <= rd_req_i && rd_ok_d;
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_ok_o = rd_ok_q;
  assign trace_write_pointer_o = wp_q;
  assign wrapped_o = wrapped_q;
  assign trace_group_o = group_q;
  assign trace_data_addr_o = tda_q;
  assign dm_addr_ok_o = tda_in_win;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ptr_step;
    @(posedge clk_i) disable iff (srst_i)
    rec && !group_change && !start_i |=> wp_q == $past(wp_q) + 13'd1;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer did not advance");

  property p_wrap;
    @(posedge clk_i) disable iff (srst_i)
    rec && !group_change && !start_i && wp_q == TRACE_LAST_IDX
      |=> wp_q == 13'd0 && wrapped_q;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer wrap wrong");

  property p_group_clr;
    @(posedge clk_i) disable iff (srst_i)
    group_change |=> wp_q == 13'd0 && !wrapped_q;
  endproperty
  a_group_clr: assert property (p_group_clr)
    else $error("group change kept pointer");

  property p_dm_narrow;
    @(posedge clk_i) disable iff (srst_i)
    dm_hit && !dm_wr_i.wide
      |=> dm_q == {DM_PAD_NIBBLE, $past(dm_wr_i.data[3:0])};
  endproperty
  a_dm_narrow: assert property (p_dm_narrow)
    else $error("narrow write not padded");

  property p_dm_hold;
    @(posedge clk_i) disable iff (srst_i)
    !dm_hit |=> $stable(dm_q);
  endproperty
  a_dm_hold: assert property (p_dm_hold)
    else $error("data field changed without match");

  property p_no_enable;
    @(posedge clk_i) disable iff (srst_i)
    addr_trace_mode_i && !step_trace_en_i && !group_change && !start_i
      |=> $stable(wp_q);
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("step traced without enable bit");

  property p_rd_unwrapped;
    @(posedge clk_i) disable iff (srst_i)
    rd_req_i && !wrapped_q && rd_idx >= wp_q |=> rd_valid_o && !rd_ok_o;
  endproperty
  a_rd_unwrapped: assert property (p_rd_unwrapped)
    else $error("unwritten entry marked valid");

  property p_rd_wrapped;
    @(posedge clk_i) disable iff (srst_i)
    rd_req_i && wrapped_q |=> rd_ok_o;
  endproperty
  a_rd_wrapped: assert property (p_rd_wrapped)
    else $error("wrapped entry marked invalid");

  property p_small_p4;
    @(posedge clk_i) disable iff (srst_i)
    chip_mode_i == MODE_SMALL && group_q != GRP_FLAGS
      |-> entry.extra[7:4] == 4'h0;
  endproperty
  a_small_p4: assert property (p_small_p4)
    else $error("port four present in small mode");

  c_wrap: cover property (@(posedge clk_i) rec && wp_q == TRACE_LAST_IDX);
  c_wide: cover property (@(posedge clk_i) dm_hit && dm_wr_i.wide);
  c_grp: cover property (@(posedge clk_i) group_change);
  c_back: cover property (@(posedge clk_i) rd_req_i && rd_back_i);

endmodule : trace_capture

// ---- test/core_model.sv ----
`timescale 1ns/1ps
module core_model
  import trace_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic slow_i,
  input wire logic [12:0] pc_i,
  input wire logic [13:0] count_i,
  input wire logic [10:0] dm_addr_i,
  output logic busy_o,
  output logic step_valid_o,
  output logic [12:0] step_pc_o,
  output logic step_trace_en_o,
  output core_state_t core_state_o,
  output logic dm_wr_valid_o,
  output dm_write_t dm_wr_o
);
  logic [12:0] pc_q;
  logic [13:0] rem_q;
  logic tick_q;
  logic fire;
  logic [54:0] snap;
  logic [7:0] wd;

  ////////////////////////////////////////////////////////////////////////
  // Runs count_i instructions from pc_i, every other cycle when slow
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_q <= '0;
      rem_q <= '0;
      tick_q <= 1'b0;
      step_valid_o <= 1'b0;
    end else if (load_i) begin
      pc_q <= pc_i;
      rem_q <= count_i;
      step_valid_o <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
      if (step_valid_o) begin
        pc_q <= pc_q + 13'h1;
      end
      step_valid_o <= fire;
      if (fire) begin
        rem_q <= rem_q - 14'h1;
      end
    end
  end

  // State follows the address; buses show the inverse between steps
  assign fire = (rem_q != 14'h0) && !(slow_i && tick_q);
  assign snap = {pc_q, ~pc_q, pc_q, ~pc_q, pc_q[2:0]};
  assign wd = pc_q[7:0] ^ 8'h3c;
  assign busy_o = (rem_q != 14'h0) || step_valid_o;
  assign step_pc_o = step_valid_o ? pc_q : ~pc_q;
  assign step_trace_en_o = ~pc_q[1];
  assign core_state_o = core_state_t'(step_valid_o ? snap : ~snap);
  assign dm_wr_valid_o = step_valid_o & pc_q[0];
  assign dm_wr_o = dm_wr_valid_o ? dm_write_t'{dm_addr_i, wd, pc_q[1]}
                                 : dm_write_t'{~dm_addr_i, ~wd, ~pc_q[1]};
endmodule : core_model

// ---- test/tb_trace_capture.sv ----
`timescale 1ns/1ps
module tb_trace_capture
  import trace_pkg::*;
;
  typedef struct packed {
    chip_mode_t m;
    trace_group_t g;
    logic [10:0] da;
    logic [12:0] pc;
    logic [13:0] n;
    logic atm;
    logic slow;
    logic ok;
    logic [12:0] ptr;
  } row_t;
  // Mode, group, address, start, steps, address mode, stall; window, count
  localparam row_t ROWS [6] = '{
    '{MODE_SMALL, GRP_FLAGS, 11'h780, 13'h7dc, 14'h6, 1'h0, 1'h0, 1'h1, 13'h6},
    '{MODE_SMALL, GRP_P4_P0, 11'h77f, 13'h010, 14'h4, 1'h0, 1'h0, 1'h0, 13'h4},
    '{MODE_MID, GRP_P4_P1, 11'h700, 13'hfdd, 14'h5, 1'h1, 1'h0, 1'h1, 13'h3},
    '{MODE_LARGE, GRP_FLAGS, 11'h5ff, 13'h1fdd, 14'h5, 1'h0, 1'h1, 1'h0, 13'h5},
    '{MODE_LARGE, GRP_P4_P0, 11'h600, 13'h020, 14'h8, 1'h1, 1'h1, 1'h1, 13'h4},
    '{MODE_MID, GRP_FLAGS, 11'h7ff, 13'h000, 14'h3, 1'h0, 1'h0, 1'h1, 13'h3}
  };
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  chip_mode_t chip_mode_i = MODE_LARGE;
  logic run_i = 1'b1, start_i = 1'b0, addr_trace_mode_i = 1'b0;
  logic set_trace_data_address_cmd_i = 1'b0;
  logic select_trace_group_cmd_i = 1'b0;
  logic [10:0] trace_data_addr_i = 11'h0;
  trace_group_t trace_group_i = GRP_FLAGS;
  logic [12:0] cov_rd_addr_i = 13'h0, rd_num_i = 13'h0;
  logic rd_req_i = 1'b0, rd_back_i = 1'b0;
  logic step_valid_i, step_trace_en_i, dm_wr_valid_i, cov_rd_data_o;
  logic [12:0] step_pc_i, trace_write_pointer_o, lp, eptr, lpc;
  core_state_t core_state_i;
  dm_write_t dm_wr_i;
  logic rd_valid_o, rd_ok_o, wrapped_o, dm_addr_ok_o;
  trace_entry_t rd_data_o, d;
  trace_group_t trace_group_o, grp;
  logic [10:0] trace_data_addr_o, tda, wr_addr = 11'h0;
  logic ld = 1'b0, slow = 1'b0, busy, ok, have, cur_ok;
  logic [12:0] ld_pc = 13'h0;
  logic [13:0] ld_n = 14'h0;
  logic [7:0] dmf;
  trace_entry_t exp_mem [8192];
  row_t r;
  int failures = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock and the two parties
  always #2 clk_i = ~clk_i;

  trace_capture dut_u (
    .clk_i, .srst_i, .chip_mode_i, .run_i, .start_i, .step_valid_i,
    .step_pc_i, .step_trace_en_i, .core_state_i, .dm_wr_valid_i, .dm_wr_i,
    .addr_trace_mode_i, .set_trace_data_address_cmd_i, .trace_data_addr_i,
    .select_trace_group_cmd_i, .trace_group_i, .cov_rd_addr_i,
    .cov_rd_data_o, .rd_req_i, .rd_back_i, .rd_num_i, .rd_valid_o, .rd_ok_o,
    .rd_data_o, .trace_write_pointer_o, .wrapped_o, .trace_group_o,
    .trace_data_addr_o, .dm_addr_ok_o
  );

  core_model core_u (
    .clk_i, .srst_i, .load_i(ld), .slow_i(slow), .pc_i(ld_pc),
    .count_i(ld_n), .dm_addr_i(wr_addr), .busy_o(busy),
    .step_valid_o(step_valid_i), .step_pc_o(step_pc_i),
    .step_trace_en_o(step_trace_en_i), .core_state_o(core_state_i),
    .dm_wr_valid_o(dm_wr_valid_i), .dm_wr_o(dm_wr_i)
  );

  // Expected entry: previous step's state plus the captured data
  function automatic trace_entry_t mk(input logic [12:0] p, input logic v);
    core_state_t s;
    logic [3:0] p4;
    s = v ? core_state_t'({p, ~p, p, ~p, p[2:0]}) : '0;
    p4 = (chip_mode_i == MODE_SMALL) ? 4'h0 : s.port_four;
    mk = '{7'h0, s.b, s.a, s.h, s.l, s.carry, s.sp, dmf, s.port_two,
           s.port_three, 16'h0};
    if (grp == GRP_FLAGS) begin
      mk.extra = {6'h0, s.condition_flag_one, s.condition_flag_two,
                  s.status_reg_low, s.status_reg_high};
    end else begin
      mk.extra = {8'h0, p4, (grp == GRP_P4_P0) ? s.port_zero : s.port_one};
    end
  endfunction : mk

  // Reference store fed from the core's steps and data writes
  always @(posedge clk_i) begin
    if (!srst_i && run_i && step_valid_i) begin
      if (!addr_trace_mode_i || step_trace_en_i) begin
        exp_mem[eptr] = mk(lpc, have);
        eptr = eptr + 13'h1;
      end
      lpc = step_pc_i;
      have = 1'b1;
    end
    if (!srst_i && run_i && dm_wr_valid_i && dm_wr_i.addr == tda && cur_ok)
      dmf = dm_wr_i.wide ? dm_wr_i.data : {4'hf, dm_wr_i.data[3:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    srst_i = 1'b1;
    have = 1'b0;
    dmf = 8'hff;
    eptr = 13'h0;
    grp = GRP_FLAGS;
    tda = 11'h700;
    cur_ok = 1'b1;
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
  endtask : do_reset

  task automatic sel(input trace_group_t g);
    trace_group_i = g;
    select_trace_group_cmd_i = 1'b1;
    if (g != grp)
      eptr = 13'h0;
    grp = g;
    @(negedge clk_i);
    select_trace_group_cmd_i = 1'b0;
  endtask : sel

  task automatic set_addr(input logic [10:0] a);
    trace_data_addr_i = a;
    set_trace_data_address_cmd_i = 1'b1;
    tda = a;
    @(negedge clk_i);
    set_trace_data_address_cmd_i = 1'b0;
  endtask : set_addr

  task automatic go(input logic st, input logic [12:0] pc,
                    input logic [13:0] n);
    start_i = st;
    ld = 1'b1;
    ld_pc = pc;
    ld_n = n;
    if (st)
      eptr = 13'h0;
    @(negedge clk_i);
    start_i = 1'b0;
    ld = 1'b0;
    for (int k = 0; k < 9000 && busy; k++)
      @(negedge clk_i);
  endtask : go

  task automatic rd(input logic b, input logic [12:0] num);
    rd_req_i = 1'b1;
    rd_back_i = b;
    rd_num_i = num;
    @(negedge clk_i);
    rd_req_i = 1'b0;
    chk(64'(rd_valid_o), 64'h1);
    ok = rd_ok_o;
    d = rd_data_o;
    // Strobe stays low for a cycle; answer must stand one cycle only
    @(negedge clk_i);
    chk(64'(rd_valid_o), 64'h0);
  endtask : rd

  task automatic cov(input logic [12:0] a, input logic e);
    cov_rd_addr_i = a;
    @(negedge clk_i);
    chk(64'(cov_rd_data_o), 64'(e));
  endtask : cov

  ////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the longest expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end

  // Table rows, then run_i low, wrap, group change and reset before a fresh run
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      r = ROWS[i];
      chip_mode_i = r.m;
      addr_trace_mode_i = r.atm;
      slow = r.slow;
      wr_addr = r.da;
      cur_ok = r.ok;
      sel(r.g);
      set_addr(r.da);
      chk(64'(dm_addr_ok_o), 64'(r.ok));
      chk(64'(trace_data_addr_o), 64'(r.da));
      chk(64'(trace_group_o), 64'(r.g));
      go(1'b1, r.pc, r.n);
      chk(64'(trace_write_pointer_o), 64'(r.ptr));
      for (int k = 0; k <= int'(r.ptr); k++) begin
        rd(1'b0, 13'(k));
        chk(64'(ok), 64'(k < int'(r.ptr)));
        if (k < int'(r.ptr))
          chk(d, exp_mem[k]);
      end
      rd(1'b1, 13'h1);
      chk(d, exp_mem[r.ptr - 13'h1]);
      lp = r.pc + 13'(r.n) - 13'h1;
      cov(r.pc, 1'b1);
      cov(lp, lp <= ((r.m == MODE_SMALL) ? CODE_LIMIT_SMALL : (r.m ==
          MODE_MID) ? CODE_LIMIT_MID : CODE_LIMIT_LARGE));
      cov(ROWS[(i + 5) % 6].pc, 1'b0);
    end
    run_i = 1'b0;
    go(1'b0, 13'h100, 14'h3);
    chk(64'(trace_write_pointer_o), 64'h3);
    cov(13'h100, 1'b0);
    run_i = 1'b1;
    chip_mode_i = MODE_LARGE;
    addr_trace_mode_i = 1'b0;
    slow = 1'b0;
    sel(GRP_P4_P1);
    go(1'b1, 13'h0, 14'd8195);
    chk(64'({wrapped_o, trace_write_pointer_o}), 64'h2003);
    rd(1'b1, 13'h5);
    chk(64'(ok), 64'h1);
    chk(d, exp_mem[8190]);
    rd(1'b0, 13'h1);
    chk(d, exp_mem[1]);
    sel(GRP_P4_P1);
    chk(64'(trace_write_pointer_o), 64'h3);
    @(negedge clk_i);
    sel(GRP_FLAGS);
    chk(64'({wrapped_o, trace_write_pointer_o}), 64'h0);
    do_reset();
    chk(64'(trace_group_o), 64'(GRP_FLAGS));
    chk(64'(trace_data_addr_o), 64'(DM_ADDR_RST));
    wr_addr = 11'h701;
    go(1'b1, 13'h40, 14'h4);
    rd(1'b0, 13'h0);
    chk(d, exp_mem[0]);
    rd(1'b0, 13'h3);
    chk(64'(d.dm), 64'hff);
    tally_and_finish();
  end
endmodule : tb_trace_capture
